/* File: verilog/lpp_pkg.sv */
// constants shared by the link packet port, its checker and its testbench
// What this block does
// R1: a software write of one to the transmit trigger bit sends one packet from the outgoing words and the bit clears itself when the send completes.
// R2: while the link is in Active_U0 the port sends Port Capabilities and Port Configuration Response on its own, setting and clearing the trigger itself.
// R3: two 32-bit read-write outgoing packet words sit at offsets four and five and form the packet that is sent.
// R4: each incoming packet is captured into two 32-bit incoming words at offsets six and seven for software to read.
// R5: a 4-bit receive counter counts every received packet, wraps from fifteen to zero, and can be written by software.
// R6: any received packet sets a flag in bit seven that requests an interrupt, and software can write that flag to clear it.
// R7: after Active_U0 is reached, a received Port Configuration packet sets status bit thirty.
// R8: after Active_U0 is reached, a received Port Capabilities packet sets status bit thirty-one.
// R9: software finishes both outgoing words before triggering and leaves them alone until the trigger reads back zero.
// R10: the lower-offset word goes out first and the higher-offset word second, and received packets are stored in the same order.
package lpp_pkg;

    // register offsets, counted in register indices
    localparam logic [3:0] OFS_CONFIG  = 4'h0;
    localparam logic [3:0] OFS_TX_W0   = 4'h4;
    localparam logic [3:0] OFS_TX_W1   = 4'h5;
    localparam logic [3:0] OFS_RX_W0   = 4'h6;
    localparam logic [3:0] OFS_RX_W1   = 4'h7;
    localparam logic [3:0] OFS_RX_STAT = 4'h8;

    // field positions
    localparam int TRIGGER_BIT   = 0;
    localparam int COUNT_LSB     = 0;
    localparam int COUNT_W       = 4;
    localparam int ANY_FLAG_BIT  = 7;
    localparam int CFG_SEEN_BIT  = 30;
    localparam int CAP_SEEN_BIT  = 31;

    // reset values
    localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
    localparam logic [3:0]  COUNT_RESET = 4'h0;

    // link management packet header layout in word 0
    localparam int PKT_TYPE_LSB    = 0;
    localparam int PKT_TYPE_W      = 5;
    localparam int PKT_SUBTYPE_LSB = 5;
    localparam int PKT_SUBTYPE_W   = 4;

    // header codes used to recognise and build management packets
    localparam logic [4:0] TYPE_LINK_MGMT    = 5'h00;
    localparam logic [3:0] SUB_PORT_CAP      = 4'h1;
    localparam logic [3:0] SUB_PORT_CFG      = 4'h2;
    localparam logic [3:0] SUB_PORT_CFG_RESP = 4'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SW_SEND,
        ST_CAP_SEND,
        ST_RESP_SEND
    } lpp_state_type;

endpackage

/* File: verilog/lpp_tx_sender.sv */
// holds one two-word packet on the link until the link takes it
`timescale 1ns/1ps
module lpp_tx_sender #(
    parameter int WORD_W = 32
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // request from the port
    input  wire logic              start,
    input  wire logic [WORD_W-1:0] word0,
    input  wire logic [WORD_W-1:0] word1,
    output logic                   done,
    // link side
    output logic                   tx_valid,
    output logic [WORD_W-1:0]      tx_word0,
    output logic [WORD_W-1:0]      tx_word1,
    input  wire logic              tx_ready
);

    logic              valid_reg;
    logic              valid_next;
    logic              done_reg;
    logic              done_next;
    logic [WORD_W-1:0] w0_reg;
    logic [WORD_W-1:0] w0_next;
    logic [WORD_W-1:0] w1_reg;
    logic [WORD_W-1:0] w1_next;

    always_comb begin
        valid_next = valid_reg;
        done_next  = 1'b0;
        w0_next    = w0_reg;
        w1_next    = w1_reg;
        if (valid_reg) begin
            if (tx_ready) begin
                valid_next = 1'b0;
                done_next  = 1'b1;
            end
        end else if (start) begin
            // copy taken so later register writes cannot corrupt the frame
            valid_next = 1'b1;
            w0_next    = word0; // see R10
            w1_next    = word1; // see R10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
            done_reg  <= 1'b0;
            w0_reg    <= '0;
            w1_reg    <= '0;
        end else begin
            valid_reg <= valid_next;
            done_reg  <= done_next;
            w0_reg    <= w0_next;
            w1_reg    <= w1_next;
        end
    end

    assign tx_valid = valid_reg;
    assign tx_word0 = w0_reg;
    assign tx_word1 = w1_reg;
    assign done     = done_reg;

endmodule

/* File: verilog/lpp_packet_port.sv */
// multi-purpose packet port: registers, automatic management replies and receive capture
`timescale 1ns/1ps
module lpp_packet_port #(
    parameter logic [31:0] AUTO_WORD1 = 32'h0000_0000
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // link state
    input  wire logic        link_u0,
    // outgoing packet toward the link
    output logic             tx_valid,
    output logic      [31:0] tx_word0,
    output logic      [31:0] tx_word1,
    input  wire logic        tx_ready,
    // incoming packet from the link
    input  wire logic        rx_valid,
    input  wire logic [31:0] rx_word0,
    input  wire logic [31:0] rx_word1,
    // interrupt request
    output logic             rx_irq
);

    // recognise a management packet of a given subtype
    function automatic logic is_mgmt(input logic [31:0] w0, input logic [3:0] sub);
        logic type_ok;
        logic sub_ok;
        type_ok = (w0[lpp_pkg::PKT_TYPE_LSB +: lpp_pkg::PKT_TYPE_W]
                   == lpp_pkg::TYPE_LINK_MGMT);
        sub_ok  = (w0[lpp_pkg::PKT_SUBTYPE_LSB +: lpp_pkg::PKT_SUBTYPE_W] == sub);
        return type_ok && sub_ok;
    endfunction

    // build word 0 of a management packet
    function automatic logic [31:0] mgmt_word0(input logic [3:0] sub);
        logic [31:0] w;
        w = '0;
        w[lpp_pkg::PKT_TYPE_LSB +: lpp_pkg::PKT_TYPE_W]       = lpp_pkg::TYPE_LINK_MGMT;
        w[lpp_pkg::PKT_SUBTYPE_LSB +: lpp_pkg::PKT_SUBTYPE_W] = sub;
        return w;
    endfunction

    // register state
    logic [31:0]                  tx_w0_reg;
    logic [31:0]                  tx_w0_next;
    logic [31:0]                  tx_w1_reg;
    logic [31:0]                  tx_w1_next;
    logic [31:0]                  rx_w0_reg;
    logic [31:0]                  rx_w0_next;
    logic [31:0]                  rx_w1_reg;
    logic [31:0]                  rx_w1_next;
    logic [3:0]                   count_reg;
    logic [3:0]                   count_next;
    logic                         any_reg;
    logic                         any_next;
    logic                         cfg_seen_reg;
    logic                         cfg_seen_next;
    logic                         cap_seen_reg;
    logic                         cap_seen_next;
    logic [31:0]                  rdata_reg;
    logic [31:0]                  rdata_next;

    // sequencing state
    lpp_pkg::lpp_state_type       state_reg;
    lpp_pkg::lpp_state_type       state_next;
    logic                         trigger_reg;
    logic                         trigger_next;
    logic                         u0_prev_reg;
    logic                         u0_prev_next;
    logic                         pend_cap_reg;
    logic                         pend_cap_next;
    logic                         pend_resp_reg;
    logic                         pend_resp_next;

    // sender handshake
    logic                         snd_start;
    logic [31:0]                  snd_w0;
    logic [31:0]                  snd_w1;
    logic                         snd_done;

    // decoded accesses
    logic wr_config;
    logic wr_tx0;
    logic wr_tx1;
    logic wr_rx0;
    logic wr_rx1;
    logic wr_stat;
    logic rx_is_cfg;
    logic rx_is_cap;

    assign wr_config = reg_wr && (reg_addr == lpp_pkg::OFS_CONFIG);
    assign wr_tx0    = reg_wr && (reg_addr == lpp_pkg::OFS_TX_W0);
    assign wr_tx1    = reg_wr && (reg_addr == lpp_pkg::OFS_TX_W1);
    assign wr_rx0    = reg_wr && (reg_addr == lpp_pkg::OFS_RX_W0);
    assign wr_rx1    = reg_wr && (reg_addr == lpp_pkg::OFS_RX_W1);
    assign wr_stat   = reg_wr && (reg_addr == lpp_pkg::OFS_RX_STAT);
    assign rx_is_cfg = rx_valid && is_mgmt(rx_word0, lpp_pkg::SUB_PORT_CFG);
    assign rx_is_cap = rx_valid && is_mgmt(rx_word0, lpp_pkg::SUB_PORT_CAP);

    // register file: writes, receive capture and status
    always_comb begin
        tx_w0_next    = tx_w0_reg;
        tx_w1_next    = tx_w1_reg;
        rx_w0_next    = rx_w0_reg;
        rx_w1_next    = rx_w1_reg;
        count_next    = count_reg;
        any_next      = any_reg;
        cfg_seen_next = cfg_seen_reg;
        cap_seen_next = cap_seen_reg;
        if (wr_tx0) begin
            tx_w0_next = reg_wdata; // see R3
        end
        if (wr_tx1) begin
            tx_w1_next = reg_wdata; // see R3
        end
        if (wr_rx0) begin
            rx_w0_next = reg_wdata;
        end
        if (wr_rx1) begin
            rx_w1_next = reg_wdata;
        end
        if (wr_stat) begin
            count_next = reg_wdata[lpp_pkg::COUNT_LSB +: lpp_pkg::COUNT_W]; // see R5
            any_next   = reg_wdata[lpp_pkg::ANY_FLAG_BIT]; // see R6
        end
        // capture beats a simultaneous write, except the count, which takes the written value plus one
        if (rx_valid) begin
            rx_w0_next = rx_word0; // see R4, R10
            rx_w1_next = rx_word1; // see R4, R10
            count_next = count_next + 4'h1; // see R5
            any_next   = 1'b1; // see R6
        end
        if (!link_u0) begin
            cfg_seen_next = 1'b0;
            cap_seen_next = 1'b0;
        end else begin
            if (rx_is_cfg) begin
                cfg_seen_next = 1'b1; // see R7
            end
            if (rx_is_cap) begin
                cap_seen_next = 1'b1; // see R8
            end
        end
    end

    // read data, registered one cycle after the read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = '0;
            unique case (reg_addr)
                lpp_pkg::OFS_CONFIG: begin
                    rdata_next[lpp_pkg::TRIGGER_BIT] = trigger_reg;
                end
                lpp_pkg::OFS_TX_W0: begin
                    rdata_next = tx_w0_reg;
                end
                lpp_pkg::OFS_TX_W1: begin
                    rdata_next = tx_w1_reg;
                end
                lpp_pkg::OFS_RX_W0: begin
                    rdata_next = rx_w0_reg;
                end
                lpp_pkg::OFS_RX_W1: begin
                    rdata_next = rx_w1_reg;
                end
                lpp_pkg::OFS_RX_STAT: begin
                    rdata_next[lpp_pkg::COUNT_LSB +: lpp_pkg::COUNT_W] = count_reg;
                    rdata_next[lpp_pkg::ANY_FLAG_BIT]                 = any_reg;
                    rdata_next[lpp_pkg::CFG_SEEN_BIT]                 = cfg_seen_reg;
                    rdata_next[lpp_pkg::CAP_SEEN_BIT]                 = cap_seen_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // transmit sequencing: software sends and automatic management replies
    always_comb begin
        state_next     = state_reg;
        trigger_next   = trigger_reg;
        u0_prev_next   = link_u0;
        pend_cap_next  = pend_cap_reg;
        pend_resp_next = pend_resp_reg;
        snd_start      = 1'b0;
        snd_w0         = tx_w0_reg;
        snd_w1         = tx_w1_reg;
        // arm the capabilities send on entry to Active_U0 and the response on a Port Configuration received in Active_U0
        if (link_u0 && !u0_prev_reg) begin
            pend_cap_next = 1'b1; // see R2
        end
        if (link_u0 && rx_is_cfg) begin
            pend_resp_next = 1'b1; // see R2
        end
        unique case (state_reg)
            lpp_pkg::ST_IDLE: begin
                if (wr_config && reg_wdata[lpp_pkg::TRIGGER_BIT]) begin
                    state_next   = lpp_pkg::ST_SW_SEND;
                    trigger_next = 1'b1; // see R1
                    snd_start    = 1'b1; // see R1
                end else if (link_u0 && pend_cap_reg) begin
                    state_next    = lpp_pkg::ST_CAP_SEND;
                    trigger_next  = 1'b1; // see R2
                    pend_cap_next = 1'b0;
                    snd_start     = 1'b1;
                    snd_w0        = mgmt_word0(lpp_pkg::SUB_PORT_CAP);
                    snd_w1        = AUTO_WORD1;
                end else if (link_u0 && pend_resp_reg) begin
                    state_next     = lpp_pkg::ST_RESP_SEND;
                    trigger_next   = 1'b1; // see R2
                    pend_resp_next = 1'b0;
                    snd_start      = 1'b1;
                    snd_w0         = mgmt_word0(lpp_pkg::SUB_PORT_CFG_RESP);
                    snd_w1         = AUTO_WORD1;
                end
            end
            lpp_pkg::ST_SW_SEND,
            lpp_pkg::ST_CAP_SEND,
            lpp_pkg::ST_RESP_SEND: begin
                if (snd_done) begin
                    state_next   = lpp_pkg::ST_IDLE;
                    trigger_next = 1'b0; // see R1, R2
                end
            end
        endcase
        // a dropped link abandons replies not yet started
        if (!link_u0) begin
            pend_cap_next  = 1'b0;
            pend_resp_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_w0_reg     <= lpp_pkg::WORD_RESET;
            tx_w1_reg     <= lpp_pkg::WORD_RESET;
            rx_w0_reg     <= lpp_pkg::WORD_RESET;
            rx_w1_reg     <= lpp_pkg::WORD_RESET;
            count_reg     <= lpp_pkg::COUNT_RESET;
            any_reg       <= 1'b0;
            cfg_seen_reg  <= 1'b0;
            cap_seen_reg  <= 1'b0;
            rdata_reg     <= lpp_pkg::WORD_RESET;
            state_reg     <= lpp_pkg::ST_IDLE;
            trigger_reg   <= 1'b0;
            u0_prev_reg   <= 1'b0;
            pend_cap_reg  <= 1'b0;
            pend_resp_reg <= 1'b0;
        end else begin
            tx_w0_reg     <= tx_w0_next;
            tx_w1_reg     <= tx_w1_next;
            rx_w0_reg     <= rx_w0_next;
            rx_w1_reg     <= rx_w1_next;
            count_reg     <= count_next;
            any_reg       <= any_next;
            cfg_seen_reg  <= cfg_seen_next;
            cap_seen_reg  <= cap_seen_next;
            rdata_reg     <= rdata_next;
            state_reg     <= state_next;
            trigger_reg   <= trigger_next;
            u0_prev_reg   <= u0_prev_next;
            pend_cap_reg  <= pend_cap_next;
            pend_resp_reg <= pend_resp_next;
        end
    end

    lpp_tx_sender #(
        .WORD_W (32)
    ) u_sender (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .start    (snd_start),
        .word0    (snd_w0),
        .word1    (snd_w1),
        .done     (snd_done),
        .tx_valid (tx_valid),
        .tx_word0 (tx_word0),
        .tx_word1 (tx_word1),
        .tx_ready (tx_ready)
    );

    assign reg_rdata = rdata_reg;
    assign rx_irq    = any_reg; // see R6

endmodule

/* File: testbench/lpp_packet_port_chk.sv */
// assertion checker for the link packet port, bound to its ports
`timescale 1ns/1ps
module lpp_packet_port_chk #(
    parameter logic [31:0] AUTO_WORD1 = 32'h0000_0000
) (
    // watched design ports
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        link_u0,
    input wire logic        tx_valid,
    input wire logic [31:0] tx_word0,
    input wire logic [31:0] tx_word1,
    input wire logic        tx_ready,
    input wire logic        rx_valid,
    input wire logic [31:0] rx_word0,
    input wire logic [31:0] rx_word1,
    input wire logic        rx_irq
);
    logic        took_reg, took_next, cap_reg, cap_next, cfg_reg, cfg_next, mgmt;
    logic [3:0]  cnt_reg, cnt_next;
    logic [31:0] tw0_reg, tw0_next, tw1_reg, tw1_next, rx0_reg, rx0_next;
    wire         rd_st = reg_rd && reg_addr == lpp_pkg::OFS_RX_STAT;

    // shadow of what software wrote and what arrived
    always_comb begin
        mgmt = rx_valid && link_u0 && rx_word0[4:0] == lpp_pkg::TYPE_LINK_MGMT;
        took_next = tx_valid && tx_ready;
        tw0_next = reg_wr && reg_addr == lpp_pkg::OFS_TX_W0 ? reg_wdata : tw0_reg;
        tw1_next = reg_wr && reg_addr == lpp_pkg::OFS_TX_W1 ? reg_wdata : tw1_reg;
        rx0_next = reg_wr && reg_addr == lpp_pkg::OFS_RX_W0 ? reg_wdata : rx0_reg;
        cnt_next = reg_wr && reg_addr == lpp_pkg::OFS_RX_STAT ? reg_wdata[3:0] : cnt_reg;
        if (rx_valid) begin
            rx0_next = rx_word0;
            cnt_next = cnt_next + 4'h1;
        end
        cap_next = link_u0 && (cap_reg || mgmt && rx_word0[8:5] == lpp_pkg::SUB_PORT_CAP);
        cfg_next = link_u0 && (cfg_reg || mgmt && rx_word0[8:5] == lpp_pkg::SUB_PORT_CFG);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {took_reg, cap_reg, cfg_reg, cnt_reg} <= '0;
            {tw0_reg, tw1_reg, rx0_reg} <= '0;
        end else begin
            {took_reg, cap_reg, cfg_reg, cnt_reg} <= {took_next, cap_next, cfg_next, cnt_next};
            {tw0_reg, tw1_reg, rx0_reg} <= {tw0_next, tw1_next, rx0_next};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_tx_hold:
    assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_word0) && $stable(tx_word1)) else $error("offer not held");
    chk_tx_drop:
    assert property (tx_valid && tx_ready |=> !tx_valid) else $error("offer not dropped");
    chk_sw_send:
    assert property (reg_wr && reg_addr == lpp_pkg::OFS_CONFIG && reg_wdata[0] && !link_u0
        && !tx_valid && !took_reg |=> tx_valid && tx_word0 == tw0_reg && tx_word1 == tw1_reg)
        else $error("trigger did not offer the outgoing words");
    chk_irq_set:
    assert property (rx_valid |=> rx_irq) else $error("flag not set by packet");
    chk_flag_clear:
    assert property (reg_wr && reg_addr == lpp_pkg::OFS_RX_STAT && !reg_wdata[7] && !rx_valid
        |=> !rx_irq) else $error("flag not cleared");
    chk_rx_word:
    assert property (reg_rd && reg_addr == lpp_pkg::OFS_RX_W0 |=> reg_rdata == $past(rx0_reg))
        else $error("first incoming word wrong");
    chk_count_read:
    assert property (rd_st |=> reg_rdata[3:0] == $past(cnt_reg) && reg_rdata[7] == $past(rx_irq))
        else $error("count or flag wrong");
    chk_seen_bits:
    assert property (rd_st |=> reg_rdata[31:30] == $past({cap_reg, cfg_reg}))
        else $error("seen bits wrong");
    chk_auto_cap:
    assert property (link_u0 && !$past(link_u0) && !tx_valid && !took_reg ##1 link_u0 && !reg_wr
        |=> tx_valid && tx_word0[8:0] == {lpp_pkg::SUB_PORT_CAP, lpp_pkg::TYPE_LINK_MGMT}
        && tx_word1 == AUTO_WORD1) else $error("no capabilities packet");
endmodule

bind lpp_packet_port lpp_packet_port_chk #(.AUTO_WORD1(AUTO_WORD1)) lpp_packet_port_chk_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_u0(link_u0), .tx_valid(tx_valid),
    .tx_word0(tx_word0), .tx_word1(tx_word1), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_word0(rx_word0), .rx_word1(rx_word1), .rx_irq(rx_irq)
);

/* File: testbench/lpp_link_partner.sv */
// behavioural link partner: takes offered packets and sends packets on request
`timescale 1ns/1ps
module lpp_link_partner (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // high stalls every offered packet three cycles
    input  wire logic        slow,
    // packets from the port
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // packets toward the port
    output logic             rx_valid,
    output logic      [31:0] rx_word0,
    output logic      [31:0] rx_word1
);
    int   wait_cnt = 0;
    logic took, offered;

    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_word0 = 32'h0;
        rx_word1 = 32'h0;
    end

    // ready drops right after the taking edge
    always @(posedge ref_clk) begin
        took = tx_valid && tx_ready;
        offered = tx_valid;
        #1;
        if (rst || took) begin
            tx_ready = 1'b0;
            wait_cnt = 0;
        end else if (offered && wait_cnt >= (slow ? 3 : 0)) begin
            tx_ready = 1'b1;
        end else if (offered) begin
            wait_cnt++;
        end
    end

    task automatic send_pkt(input logic [31:0] w0, input logic [31:0] w1);
        @(posedge ref_clk);
        #1 rx_valid = 1'b1;
        rx_word0 = w0;
        rx_word1 = w1;
        @(posedge ref_clk);
        #1 rx_valid = 1'b0;
        rx_word0 = ~w0;
        rx_word1 = ~w1;
    endtask
endmodule

/* File: testbench/tb_link_mgmt_packet_port.sv */
// self-checking testbench for the link packet port
`timescale 1ns/1ps
module tb_link_mgmt_packet_port;
    localparam logic [31:0] AUTO_W1 = 32'h0000_5a5a;
    localparam logic [31:0] HDR     = 32'h0000_01ff;
    logic        ref_clk, rst, reg_wr, reg_rd, link_u0, slow, rd_now, tk;
    logic        tx_valid, tx_ready, rx_valid, rx_irq;
    logic [3:0]  reg_addr, cnt;
    logic [31:0] reg_wdata, reg_rdata, tx_word0, tx_word1, rx_word0, rx_word1;
    logic [31:0] a, b, w0, w1, m;
    logic [31:0] rd_q[$], tx_q[$], mask_q[$];
    int          fails = 0;
    int          samples_checked = 0;
    int          seed = 32'ha5e3;

    lpp_packet_port #(.AUTO_WORD1(AUTO_W1)) lpp_packet_port_i (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_u0(link_u0), .tx_valid(tx_valid),
        .tx_word0(tx_word0), .tx_word1(tx_word1), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_word0(rx_word0), .rx_word1(rx_word1), .rx_irq(rx_irq)
    );
    lpp_link_partner lpp_link_partner_i (
        .ref_clk(ref_clk), .rst(rst), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_word0(rx_word0), .rx_word1(rx_word1)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] d);
        @(posedge ref_clk);
        #1 reg_addr = adr;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
        @(posedge ref_clk);
        #1 reg_addr = adr;
        reg_rd = 1'b1;
        rd_q.push_back(exp);
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
    endtask

    task automatic expect_tx(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] k);
        tx_q.push_back(e0);
        tx_q.push_back(e1);
        mask_q.push_back(k);
    endtask

    // waits until every noted packet is taken and the trigger has cleared
    task automatic drain;
        int n;
        n = 0;
        while ((tx_q.size() != 0 || tx_valid !== 1'b0) && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 200) check("drain", 32'h0, 32'h1);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // compares each read answer and each taken packet with the oldest note
    always @(posedge ref_clk) begin
        rd_now = reg_rd;
        tk = tx_valid && tx_ready;
        w0 = tx_word0;
        w1 = tx_word1;
        #2;
        if (rd_now === 1'b1) check("reg_rdata", rd_q.pop_front(), reg_rdata);
        if (tk === 1'b1 && mask_q.size() == 0) begin
            fails++;
            $display("[FAIL] tx packet expected none seen %h", w0);
        end else if (tk === 1'b1) begin
            m = mask_q.pop_front();
            check("tx_word0", tx_q.pop_front() & m, w0 & m);
            check("tx_word1", tx_q.pop_front(), w1);
        end
    end

    initial begin
        repeat (4000) @(posedge ref_clk);
        fails++;
        $display("[FAIL] watchdog expected done seen hang");
        give_verdict;
    end

    initial begin
        {rst, reg_addr, reg_wr, reg_rd, reg_wdata, link_u0, slow} = {1'b1, 40'h0};
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        a = $random(seed);
        b = $random(seed);
        wr(lpp_pkg::OFS_TX_W0, a);
        wr(lpp_pkg::OFS_TX_W1, b);
        wr(lpp_pkg::OFS_RX_W0, ~a);
        wr(lpp_pkg::OFS_RX_W1, ~b);
        wr(4'h2, a);
        rd(lpp_pkg::OFS_TX_W0, a);
        rd(lpp_pkg::OFS_TX_W1, b);
        rd(lpp_pkg::OFS_RX_W0, ~a);
        rd(lpp_pkg::OFS_RX_W1, ~b);
        rd(4'h2, 32'h0);
        rd(4'hc, 32'h0);
        rd(lpp_pkg::OFS_CONFIG, 32'h0);
        wr(lpp_pkg::OFS_RX_STAT, 32'hc000_008e);
        rd(lpp_pkg::OFS_RX_STAT, 32'h0000_008e);
        $display("test registers done");
        cnt = 4'he;
        for (int i = 0; i < 17; i++) begin
            a = $random(seed);
            b = $random(seed);
            lpp_link_partner_i.send_pkt(a, b);
            cnt = cnt + 4'h1;
        end
        check("rx_irq", 32'h1, {31'h0, rx_irq});
        rd(lpp_pkg::OFS_RX_W0, a);
        rd(lpp_pkg::OFS_RX_W1, b);
        rd(lpp_pkg::OFS_RX_STAT, {24'h0, 4'h8, cnt});
        wr(lpp_pkg::OFS_RX_STAT, 32'h0);
        rd(lpp_pkg::OFS_RX_STAT, 32'h0);
        $display("test receive done");
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            a = $random(seed);
            b = $random(seed);
            wr(lpp_pkg::OFS_TX_W0, a);
            wr(lpp_pkg::OFS_TX_W1, b);
            expect_tx(a, b, 32'hffff_ffff);
            wr(lpp_pkg::OFS_CONFIG, 32'h1);
            wr(lpp_pkg::OFS_CONFIG, 32'h1);
            rd(lpp_pkg::OFS_CONFIG, {31'h0, slow});
            drain;
            rd(lpp_pkg::OFS_CONFIG, 32'h0);
        end
        $display("test software send done");
        slow = 1'b0;
        expect_tx({23'h0, lpp_pkg::SUB_PORT_CAP, lpp_pkg::TYPE_LINK_MGMT}, AUTO_W1, HDR);
        @(posedge ref_clk);
        #1 link_u0 = 1'b1;
        @(posedge ref_clk);
        rd(lpp_pkg::OFS_CONFIG, 32'h1);
        drain;
        a[8:0] = {lpp_pkg::SUB_PORT_CFG, lpp_pkg::TYPE_LINK_MGMT};
        expect_tx({23'h0, lpp_pkg::SUB_PORT_CFG_RESP, lpp_pkg::TYPE_LINK_MGMT}, AUTO_W1, HDR);
        lpp_link_partner_i.send_pkt(a, b);
        drain;
        a[8:5] = lpp_pkg::SUB_PORT_CAP;
        lpp_link_partner_i.send_pkt(a, b);
        rd(lpp_pkg::OFS_CONFIG, 32'h0);
        rd(lpp_pkg::OFS_RX_STAT, 32'hc000_0082);
        @(posedge ref_clk);
        #1 link_u0 = 1'b0;
        rd(lpp_pkg::OFS_RX_STAT, 32'h0000_0082);
        $display("test link management done");
        give_verdict;
    end
endmodule
